// ---- ssp_core.sv ----
/*
  Synchronous serial port core: master or slave, framed, SPI and half-duplex
  formats, bit clock divider, transmit and receive FIFOs, interrupt status.
  Assumes all pin inputs are synchronous to clk; configuration is held
  steady while enable is high.
*/
module ssp_core
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic enable, // Port enable
  input wire logic slave_mode, // 1 slave, 0 master
  input wire ssp_pkg::ssp_fmt_e frame_format, // Frame format
  input wire logic clock_polarity, // SPI clock idle level
  input wire logic clock_phase, // SPI capture edge
  input wire logic [3:0] data_size, // Frame size minus one
  input wire logic [7:0] clock_prescale_divisor, // Even prescale
  input wire logic [7:0] serial_clock_rate, // Second divisor minus one
  input wire logic wr_valid, // Data register write
  input wire ssp_pkg::ssp_word_t wr_data, // Word written
  output logic wr_ready, // Transmit FIFO has room
  input wire logic rd_pop, // Data register read
  output logic rd_valid, // Receive FIFO holds a word
  output ssp_pkg::ssp_word_t rd_data, // Oldest received word
  input wire logic [3:0] interrupt_mask_register, // Source enables
  output logic [3:0] raw_interrupt_status, // Raw sources
  output logic [3:0] masked_interrupt_status, // Raw and mask
  output logic irq, // Combined request
  input wire logic clear_timeout, // Clears time-out flag
  input wire logic clear_overrun, // Clears overrun flag
  input wire logic serial_bit_clock_in, // Clock pin level
  output logic serial_bit_clock_out, // Clock pin drive
  output logic serial_bit_clock_oe_n, // Clock pin enable, low drives
  input wire logic frame_select_in, // Select pin level
  output logic frame_select_out, // Select pin drive
  output logic frame_select_oe_n, // Select pin enable, low drives
  output logic serial_data_out, // Transmit data
  output logic serial_data_out_oe_n, // Transmit enable, low drives
  input wire logic serial_data_in // Receive data
);
  import ssp_pkg::*;

  ssp_fifo_if tx_if (); // Transmit path
  ssp_fifo_if rx_if (); // Receive path

  // Transmit and receive FIFOs
  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (.clk(clk), .rst_n(rst_n),
    .f(tx_if.fifo));
  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (.clk(clk), .rst_n(rst_n),
    .f(rx_if.fifo));

  ssp_state_e state_reg; // Link sequencer state
  logic [6:0] pre_cnt_reg; // Prescale counter
  logic [7:0] rate_cnt_reg; // Rate counter
  logic sck_act_reg; // Master clock away from idle
  logic hold_cnt_reg; // Half periods spent in hold
  logic [4:0] cap_cnt_reg; // Bits captured this frame
  logic sck_prev_reg; // Last clock pin level
  ssp_word_t sh_tx_reg; // Transmit shifter
  ssp_word_t sh_rx_reg; // Receive shifter
  logic txd_reg; // Bit on the data pin
  logic [6:0] to_cnt_reg; // Idle half periods
  logic to_reg; // Time-out flag
  logic ovr_reg; // Overrun flag

  logic [6:0] pre_half; // Half of the even prescale
  logic pre_tick; // Prescale wrap
  logic half_tick; // One half bit period
  logic is_spi; // SPI format
  logic is_half; // Half-duplex format
  logic is_framed; // Framed format
  logic idle_lvl; // Clock idle level
  logic cap_first; // Capture on the leading edge
  logic [3:0] size_m1; // Clamped frame size minus one
  logic [4:0] total_bits; // Clock periods per frame
  logic sck_edge; // Slave saw a clock change
  logic sck_away; // Clock pin away from idle
  logic ev_lead; // Leading clock edge
  logic ev_trail; // Trailing clock edge
  logic cap_ev; // Capture edge
  logic drv_ev; // Drive edge
  logic cap_done; // Last bit captured
  logic accept; // Capture is kept
  logic mst_start; // Master opens a frame
  logic slv_start; // Slave sees a frame open
  logic hold_last; // Master hold ends
  logic mst_more; // Master continues with select low
  logic slv_more; // Slave continues with select low
  logic mst_end; // Master clocked out the frame
  logic load; // Take a word into the shifter
  logic rx_push; // Received word ready
  ssp_word_t aligned; // Word placed MSB first

  // Format decode
  assign is_spi = (frame_format == FMT_SPI);
  assign is_half = (frame_format == FMT_HALF);
  assign is_framed = !is_spi && !is_half;
  assign idle_lvl = is_spi && clock_polarity;
  assign cap_first = is_half || (is_spi && !clock_phase);
  assign size_m1 = (data_size < MIN_SIZE_M1) ? MIN_SIZE_M1 : data_size;
  // Half-duplex adds control byte and turnaround to the response
  assign total_bits = (is_half ? SKIP_BITS : 5'h00) + {1'b0, size_m1} + 5'h01;

  // Divider: half the even prescale, then one plus rate, gives half periods
  assign pre_half = (clock_prescale_divisor[7:1] == 7'h00) ? 7'h01
    : clock_prescale_divisor[7:1];
  assign pre_tick = (pre_cnt_reg == pre_half - 7'h01);
  assign half_tick = pre_tick && (rate_cnt_reg == serial_clock_rate);

  // Prescale counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt_reg <= 7'h00;
    else if (!enable || pre_tick)
      pre_cnt_reg <= 7'h00;
    else
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
  end

  // Rate counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rate_cnt_reg <= 8'h00;
    else if (!enable || half_tick)
      rate_cnt_reg <= 8'h00;
    else if (pre_tick)
      rate_cnt_reg <= rate_cnt_reg + 8'h01;
  end

  // Slave clock edge detect on the synchronous pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sck_prev_reg <= 1'b0;
    else
      sck_prev_reg <= serial_bit_clock_in;
  end
  assign sck_edge = (serial_bit_clock_in != sck_prev_reg);
  assign sck_away = (serial_bit_clock_in != idle_lvl);

  // Leading and trailing edges of the active frame
  always_comb
  begin
    ev_lead = 1'b0;
    ev_trail = 1'b0;
    if (state_reg == ST_SHIFT && slave_mode)
    begin
      ev_lead = sck_edge && sck_away;
      ev_trail = sck_edge && !sck_away;
    end
    else if (state_reg == ST_SHIFT)
    begin
      ev_lead = half_tick && !sck_act_reg;
      ev_trail = half_tick && sck_act_reg;
    end
  end
  assign cap_ev = cap_first ? ev_lead : ev_trail;
  assign drv_ev = cap_first ? ev_trail : ev_lead;
  assign cap_done = cap_ev && (cap_cnt_reg == total_bits - 5'h01);
  assign accept = !(is_half && cap_cnt_reg < SKIP_BITS);

  // Frame start and continuation
  assign mst_start = !slave_mode && enable && state_reg == ST_IDLE && half_tick
    && tx_if.out_valid;
  assign slv_start = slave_mode && enable && state_reg == ST_IDLE
    && (is_framed ? (frame_select_in && sck_edge && !sck_away) : !frame_select_in);
  assign hold_last = !slave_mode && state_reg == ST_HOLD && half_tick
    && (is_framed || hold_cnt_reg);
  assign mst_more = hold_last && is_spi && clock_phase && tx_if.out_valid;
  assign slv_more = slave_mode && cap_done && is_spi && clock_phase && !frame_select_in;
  assign mst_end = !slave_mode && ev_trail
    && cap_cnt_reg == (cap_first ? total_bits : total_bits - 5'h01);
  assign load = mst_start || slv_start || mst_more || slv_more;
  // Slave stores on the last capture, master once hold ends
  assign rx_push = slave_mode ? cap_done : hold_last;
  assign rx_if.in_valid = rx_push;
  assign rx_if.in_data = slave_mode ? {sh_rx_reg[DATA_W-2:0], serial_data_in} : sh_rx_reg;
  assign rx_if.out_ready = rd_pop;
  assign tx_if.in_valid = wr_valid;
  assign tx_if.in_data = wr_data;
  // An empty FIFO pops nothing and offers its stale slot
  assign tx_if.out_ready = load;
  assign aligned = is_half ? {tx_if.out_data[7:0], 8'h00}
    : tx_if.out_data << (4'hF - size_m1);

  // Link sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_IDLE;
    else if (!enable)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (mst_start)
            state_reg <= is_framed ? ST_SYNC : ST_SETUP;
          else if (slv_start)
            state_reg <= ST_SHIFT;
        ST_SYNC:
          // Select pulse spans one full clock period
          if (half_tick && sck_act_reg)
            state_reg <= ST_SHIFT;
        ST_SETUP:
          // Select low a full period before the first edge
          if (half_tick)
            state_reg <= ST_SHIFT;
        ST_SHIFT:
          if (slave_mode && !is_framed && frame_select_in)
            state_reg <= ST_IDLE;
          else if (slave_mode && cap_done && !slv_more)
            state_reg <= is_framed ? ST_IDLE : ST_HOLD;
          else if (mst_end)
            state_reg <= ST_HOLD;
        ST_HOLD:
          if (slave_mode && frame_select_in)
            state_reg <= ST_IDLE;
          else if (hold_last)
            state_reg <= mst_more ? ST_SETUP : ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Master clock toggles only in the sync period and while shifting
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sck_act_reg <= 1'b0;
    else if (!enable || slave_mode || !(state_reg == ST_SYNC || state_reg == ST_SHIFT))
      sck_act_reg <= 1'b0;
    else if (half_tick)
      sck_act_reg <= !sck_act_reg;
  end

  // Master hold lasts two half periods, one in framed format
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_cnt_reg <= 1'b0;
    else if (state_reg != ST_HOLD)
      hold_cnt_reg <= 1'b0;
    else if (half_tick)
      hold_cnt_reg <= 1'b1;
  end

  // Capture counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cap_cnt_reg <= 5'h00;
    else if (load)
      cap_cnt_reg <= 5'h00;
    else if (cap_ev)
      cap_cnt_reg <= cap_cnt_reg + 5'h01;
  end

  // Shifters: MSB first out, new bits enter at the bottom
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_tx_reg <= WORD_ZERO;
      sh_rx_reg <= WORD_ZERO;
      txd_reg <= 1'b0;
    end
    else if (load)
    begin
      sh_rx_reg <= WORD_ZERO;
      if (cap_first)
      begin
        txd_reg <= aligned[DATA_W-1];
        sh_tx_reg <= aligned << 1;
      end
      else
        sh_tx_reg <= aligned;
    end
    else
    begin
      if (drv_ev)
      begin
        txd_reg <= sh_tx_reg[DATA_W-1];
        sh_tx_reg <= sh_tx_reg << 1;
      end
      else if (state_reg == ST_IDLE)
        txd_reg <= 1'b0;
      if (cap_ev && accept)
        sh_rx_reg <= {sh_rx_reg[DATA_W-2:0], serial_data_in};
    end
  end

  // Idle time-out counter, in half periods
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      to_cnt_reg <= 7'h00;
    else if (state_reg != ST_IDLE || !rx_if.out_valid)
      to_cnt_reg <= 7'h00;
    else if (half_tick && to_cnt_reg != TIMEOUT_HALVES)
      to_cnt_reg <= to_cnt_reg + 7'h01;
  end

  // Sticky flags; a new event wins over a clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      to_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == ST_IDLE && rx_if.out_valid && half_tick
          && to_cnt_reg == TIMEOUT_HALVES - 7'h01)
        to_reg <= 1'b1;
      else if (clear_timeout)
        to_reg <= 1'b0;
      if (rx_push && !rx_if.in_ready)
        ovr_reg <= 1'b1;
      else if (clear_overrun)
        ovr_reg <= 1'b0;
    end
  end

  // Interrupt status
  always_comb
  begin
    raw_interrupt_status = 4'h0;
    raw_interrupt_status[IRQ_TX] = (tx_if.level <= SERVICE_LEVEL);
    raw_interrupt_status[IRQ_RX] = (rx_if.level >= SERVICE_LEVEL);
    raw_interrupt_status[IRQ_TO] = to_reg;
    raw_interrupt_status[IRQ_OVR] = ovr_reg;
  end
  assign masked_interrupt_status = raw_interrupt_status & interrupt_mask_register;
  assign irq = |masked_interrupt_status;

  // CPU data path
  assign wr_ready = tx_if.in_ready;
  assign rd_valid = rx_if.out_valid;
  assign rd_data = rx_if.out_data;

  // Pins
  assign serial_bit_clock_out = idle_lvl ^ sck_act_reg;
  assign serial_bit_clock_oe_n = slave_mode;
  assign frame_select_out = is_framed ? (state_reg == ST_SYNC)
    : (state_reg == ST_IDLE);
  assign frame_select_oe_n = slave_mode;
  assign serial_data_out = txd_reg;
  assign serial_data_out_oe_n = (slave_mode || is_framed) && state_reg == ST_IDLE;

  // Helper: cycles since the last half period
  logic [15:0] gap_reg;
  logic [15:0] gap_want;
  assign gap_want = {9'h000, pre_half} * ({8'h00, serial_clock_rate} + 16'h0001) - 16'h0001;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gap_reg <= 16'h0000;
    else if (!enable || half_tick)
      gap_reg <= 16'h0000;
    else
      gap_reg <= gap_reg + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_divider;
    enable && half_tick |-> gap_reg == gap_want;
  endproperty
  a_divider: assert property (p_divider) else $error("bit rate divisor wrong");

  property p_idle_clock;
    !slave_mode && state_reg == ST_IDLE |-> serial_bit_clock_out == idle_lvl;
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("clock moved while idle");

  property p_select_low;
    !slave_mode && !is_framed && state_reg == ST_SHIFT |-> !frame_select_out;
  endproperty
  a_select_low: assert property (p_select_low) else $error("select high in frame");

  property p_sync_pulse;
    !slave_mode && is_framed && $fell(frame_select_out)
      |-> state_reg == ST_SHIFT && !serial_bit_clock_out && $past(sck_act_reg);
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("select pulse not one period");

  property p_overrun;
    rx_push && !rx_if.in_ready |=> raw_interrupt_status[IRQ_OVR] && irq
      == |(raw_interrupt_status & interrupt_mask_register);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_ctrl_ignored;
    is_half && cap_ev && !accept && !load |=> $stable(sh_rx_reg);
  endproperty
  a_ctrl_ignored: assert property (p_ctrl_ignored) else $error("input taken during control");

  property p_timeout;
    $rose(to_reg) |-> $past(rx_if.out_valid) && $past(state_reg) == ST_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out without idle data");

  property p_framed_idle;
    !slave_mode && is_framed && state_reg == ST_IDLE
      |-> serial_data_out_oe_n && !frame_select_out && !serial_bit_clock_out;
  endproperty
  a_framed_idle: assert property (p_framed_idle) else $error("framed idle pins wrong");

  c_framed_word: cover property (is_framed && !slave_mode && rx_push);
  c_half_word: cover property (is_half && !slave_mode && rx_push);
  c_overrun: cover property (rx_push && !rx_if.in_ready);
endmodule : ssp_core

// ---- ssp_pkg.sv ----
/*
  Shared constants and types of the synchronous serial port core.
  Assumes a single 20 MHz system clock and an active-low asynchronous reset.
*/
package ssp_pkg;
  // System clock rate
  localparam int CLK_HZ = 20_000_000;
  // Word width and FIFO depth
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  // Width of a FIFO fill level
  localparam int LVL_W = 4;
  // Smallest frame size, stored as size minus one
  localparam logic [3:0] MIN_SIZE_M1 = 4'h3;
  // Control message length and slave turnaround in half-duplex format
  localparam logic [4:0] CTRL_BITS = 5'h08;
  localparam logic [4:0] WAIT_BITS = 5'h01;
  localparam logic [4:0] SKIP_BITS = CTRL_BITS + WAIT_BITS;
  // Receive time-out in bit periods, and as half periods
  localparam int TIMEOUT_BITS = 32;
  localparam logic [6:0] TIMEOUT_HALVES = 7'(2 * TIMEOUT_BITS);
  // FIFO level that asks for service
  localparam logic [LVL_W-1:0] SERVICE_LEVEL = 4'h4;
  // Positions of the four interrupt sources
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_TO = 2;
  localparam int IRQ_OVR = 3;
  // Reset value of the transmit and receive shifters
  localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
  // Frame formats
  typedef enum logic [1:0] {FMT_FRAMED, FMT_SPI, FMT_HALF} ssp_fmt_e;
  // Link sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_SETUP, ST_SHIFT, ST_HOLD} ssp_state_e;
  // One data word
  typedef logic [DATA_W-1:0] ssp_word_t;
endpackage : ssp_pkg

// ---- ssp_fifo_if.sv ----
/*
  Valid/ready carrier between the port core and one of its FIFOs.
  Assumes both sides run on the same clock.
*/
interface ssp_fifo_if;
  import ssp_pkg::*;
  logic in_valid; // Word offered for push
  logic in_ready; // FIFO has room
  ssp_word_t in_data; // Word to push
  logic out_valid; // FIFO holds a word
  logic out_ready; // Consumer pops
  ssp_word_t out_data; // Oldest word, or stale slot when empty
  logic [LVL_W-1:0] level; // Fill level
  // FIFO side
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, level);
  // Core side
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, level);
endinterface : ssp_fifo_if

// ---- ssp_fifo.sv ----
/*
  Flip-flop FIFO with valid/ready on both sides and a fill level.
  Assumes one clock; storage clears at reset so an unwritten slot reads zero.
*/
module ssp_fifo
  import ssp_pkg::*;
#(
  parameter int WIDTH = DATA_W, // Word width
  parameter int DEPTH = FIFO_DEPTH // Number of entries
)
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  ssp_fifo_if.fifo f // Push and pop ports
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage
  logic [AW-1:0] wr_ptr_reg; // Next slot to write
  logic [AW-1:0] rd_ptr_reg; // Oldest slot
  logic [AW:0] count_reg; // Entries held
  logic push; // Accepted write
  logic pop; // Accepted read

  assign push = f.in_valid && f.in_ready;
  assign pop = f.out_ready && f.out_valid;
  assign f.in_ready = (count_reg != FULL);
  assign f.out_valid = (count_reg != '0);
  // Empty: the read slot is the one written DEPTH pushes ago
  assign f.out_data = mem_reg[rd_ptr_reg];
  assign f.level = LVL_W'(count_reg);

  // Storage and write pointer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= '0;
      wr_ptr_reg <= '0;
    end
    else if (push)
    begin
      mem_reg[wr_ptr_reg] <= f.in_data;
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  // Read pointer and occupancy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

  property p_full_refuses;
    @(posedge clk) disable iff (!rst_n)
    count_reg == FULL |-> !f.in_ready ##1 count_reg == FULL || $past(pop);
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("fifo took a word while full");

  property p_first_out;
    @(posedge clk) disable iff (!rst_n)
    push && !f.out_valid |=> f.out_valid && f.out_data == $past(f.in_data);
  endproperty
  a_first_out: assert property (p_first_out) else $error("fifo order broken");
endmodule : ssp_fifo

// ---- ssp_peer.sv ----
/*
  Far-side slave: SPI clock polarity 0, phase 0, 8-bit words, or half-duplex
  with an 8-bit control byte and the reply after one turnaround clock.
  Assumes a master drives clock, select and data; reply n is C0h plus n.
*/
module ssp_peer
(
  input wire logic sclk, // Link clock
  input wire logic sel_n, // Select, active low
  input wire logic mosi, // Data from master
  input wire logic half, // Half-duplex frames
  output logic miso, // Data to master
  output logic [7:0] rx_word, // Last word received
  output int n_frames // Frames completed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_sh; // Outgoing shifter
  logic [7:0] rx_sh; // Incoming shifter
  bit active; // A frame has begun
  int n_rise; // Rising clock edges in this frame
  initial
  begin
    miso = 1'b0;
    rx_word = 8'h00;
    n_frames = 0;
  end
  // Load the reply on select, MSB first
  always @(negedge sel_n)
  begin
    active = 1'b1;
    n_rise = 0;
    tx_sh = 8'hC0 + 8'(n_frames);
    miso = tx_sh[7];
  end
  // Capture on the first clock edge
  always @(posedge sclk)
    if (!sel_n)
    begin
      // Half-duplex keeps only the control byte
      if (!half || n_rise < 8)
        rx_sh = {rx_sh[6:0], mosi};
      n_rise++;
    end
  // Drive the next bit on the trailing edge
  always @(negedge sclk)
    if (!sel_n)
    begin
      // Half-duplex reply starts after the turnaround clock
      if (half && n_rise == 9)
        tx_sh = 8'hC0 + 8'(n_frames);
      else
        tx_sh = {tx_sh[6:0], 1'b0};
      miso = tx_sh[7];
    end
  // Close the frame; the released line shows no stale bit
  always @(posedge sel_n)
    if (active)
    begin
      active = 1'b0;
      rx_word = rx_sh;
      n_frames++;
      miso = ~miso;
    end
endmodule : ssp_peer

// ---- ssp_core_test.sv ----
/*
  Self-checking bench of the port core as SPI and half-duplex master, 8-bit words.
  Assumes ssp_peer answers on the far side of the link.
*/
module ssp_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ssp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, enable = 1'b0, slave_mode = 1'b0, clock_polarity = 1'b0;
  logic clock_phase = 1'b0, wr_valid = 1'b0, rd_pop = 1'b0, clear_timeout = 1'b0;
  logic clear_overrun = 1'b0;
  ssp_fmt_e frame_format = FMT_SPI; // Format under test
  logic [3:0] data_size = 4'h7; // Eight-bit frames
  logic [7:0] clock_prescale_divisor = 8'h04; // Half period 4 cycles
  logic [7:0] serial_clock_rate = 8'h01;
  logic [3:0] interrupt_mask_register = 4'h0;
  ssp_word_t wr_data = 16'h0000;
  ssp_word_t rd_data;
  logic [3:0] raw_interrupt_status, masked_interrupt_status;
  logic wr_ready, rd_valid, irq, serial_bit_clock_out, serial_bit_clock_oe_n, frame_select_out;
  logic frame_select_oe_n, serial_data_out, serial_data_out_oe_n, miso, clk_wire, sel_wire;
  logic [7:0] peer_rx; // Peer's last word
  int peer_frames, err_total = 0, n_tests = 0;
  // Pin levels: released clock pulled low, released select pulled high
  assign clk_wire = serial_bit_clock_oe_n ? 1'b0 : serial_bit_clock_out;
  assign sel_wire = frame_select_oe_n ? 1'b1 : frame_select_out;
  always #25 clk = ~clk;
  ssp_core ssp_core_inst (.clk, .rst_n, .enable, .slave_mode, .frame_format, .clock_polarity,
    .clock_phase, .data_size, .clock_prescale_divisor, .serial_clock_rate, .wr_valid, .wr_data,
    .wr_ready, .rd_pop, .rd_valid, .rd_data, .interrupt_mask_register, .raw_interrupt_status,
    .masked_interrupt_status, .irq, .clear_timeout, .clear_overrun, .serial_bit_clock_in(clk_wire),
    .serial_bit_clock_out, .serial_bit_clock_oe_n, .frame_select_in(sel_wire), .frame_select_out,
    .frame_select_oe_n, .serial_data_out, .serial_data_out_oe_n, .serial_data_in(miso));
  ssp_peer ssp_peer_inst (.sclk(clk_wire), .sel_n(sel_wire), .mosi(serial_data_out),
    .half(frame_format == FMT_HALF), .miso,
    .rx_word(peer_rx), .n_frames(peer_frames));
  // Compare one value, count it
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Verdict and end of run
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // One data register write, held one cycle
  task automatic push(input ssp_word_t w);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_data = w;
    @(negedge clk);
    wr_valid = 1'b0;
  endtask : push
  // Bounded wait for the peer's frame count, which rises once the hold ends, then 20 cycles more
  task automatic wait_frames(input int n);
    for (int k = 0; k < 5000 && peer_frames < n; k++)
      @(negedge clk);
    repeat (20) @(negedge clk);
  endtask : wait_frames
  // Reset status and masking
  task automatic t_reset;
    check("raw", 16'h0001, 16'(raw_interrupt_status));
    check("irq", 16'h0000, 16'(irq));
    check("pin_oe_n", 16'h0000, 16'({serial_bit_clock_oe_n, frame_select_oe_n}));
    check("data_oe_n", 16'h0000, 16'(serial_data_out_oe_n));
    interrupt_mask_register = 4'h1;
    @(negedge clk);
    check("masked", 16'h0001, 16'(masked_interrupt_status));
    check("irq", 16'h0001, 16'(irq));
    interrupt_mask_register = 4'h0;
  endtask : t_reset
  // Fill the transmit buffer past full while the port is off
  task automatic t_fill;
    for (int i = 0; i < 9; i++)
      push(16'h0010 + 16'(i));
    check("wr_ready", 16'h0000, 16'(wr_ready));
    check("raw", 16'h0000, 16'(raw_interrupt_status));
  endtask : t_fill
  // Stream eight words, check bit period and framing
  task automatic t_stream;
    longint t;
    enable = 1'b1;
    @(posedge clk_wire);
    t = $time;
    @(posedge clk_wire);
    check("period", 16'h0008, 16'(($time - t) / 50));
    wait_frames(8);
    check("frames", 16'h0008, 16'(peer_frames));
    check("peer_rx", 16'h0017, 16'(peer_rx));
    check("rx_service", 16'h0002, 16'(raw_interrupt_status & 4'h2));
    check("idle_pins", 16'h0002, {14'h0000, sel_wire, clk_wire});
  endtask : t_stream
  // Ninth word overruns, then idle time-out
  task automatic t_overrun;
    push(16'h00AA);
    wait_frames(9);
    check("peer_rx", 16'h00AA, 16'(peer_rx));
    check("overrun", 16'h0008, 16'(raw_interrupt_status & 4'h8));
    repeat (160) @(negedge clk);
    check("timeout", 16'h0000, 16'(raw_interrupt_status & 4'h4));
    repeat (100) @(negedge clk);
    check("timeout", 16'h0004, 16'(raw_interrupt_status & 4'h4));
    interrupt_mask_register = 4'hC;
    @(negedge clk);
    check("masked", 16'h000C, 16'(masked_interrupt_status));
    check("irq", 16'h0001, 16'(irq));
  endtask : t_overrun
  // Drain in order, clear the sticky flags
  task automatic t_drain;
    for (int i = 0; i < 8; i++)
    begin
      check("rd_data", 16'h00C0 + 16'(i), 16'(rd_data[7:0]));
      rd_pop = 1'b1;
      @(negedge clk);
      rd_pop = 1'b0;
      @(negedge clk);
    end
    clear_timeout = 1'b1;
    clear_overrun = 1'b1;
    @(negedge clk);
    clear_timeout = 1'b0;
    clear_overrun = 1'b0;
    @(negedge clk);
    check("raw", 16'h0001, 16'(raw_interrupt_status));
  endtask : t_drain
  // Half-duplex: control byte out, reply after one turnaround clock
  task automatic t_half;
    enable = 1'b0;
    frame_format = FMT_HALF;
    @(negedge clk);
    enable = 1'b1;
    push(16'h0035);
    wait_frames(10);
    check("ctrl", 16'h0035, 16'(peer_rx));
    check("rd_valid", 16'h0001, 16'(rd_valid));
    check("reply", 16'h00C9, rd_data);
  endtask : t_half
  // Polarity one idles the clock high
  task automatic t_polarity;
    enable = 1'b0;
    frame_format = FMT_SPI;
    clock_polarity = 1'b1;
    repeat (2) @(negedge clk);
    check("clk_idle", 16'h0001, 16'(serial_bit_clock_out));
  endtask : t_polarity
  // Main sequence
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_fill();
    t_stream();
    t_overrun();
    t_drain();
    t_half();
    t_polarity();
    print_verdict();
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule : ssp_core_test
